// ### rtl/xbar_pkg.sv
// shared constants and carrier types for the ram crossbar
package xbar_pkg;

    // ==========================================================
    // address map
    localparam logic [31:0] EXT_BASE = 32'h0200_0000;
    localparam int ONCHIP_MSB = 24;
    localparam int BANK_LSB = 11;
    localparam int BANK_W = 6;
    localparam int DW_LSB = 3;
    localparam int IDX_W = BANK_LSB - DW_LSB;
    localparam int DEPTH = 2 ** IDX_W;
    localparam int DW_BITS = 64;
    localparam int DW_BYTES = 8;

    // ==========================================================
    // port numbering
    localparam int P_CI = 0;
    localparam int P_CD = 1;
    localparam int P_TE = 2;
    localparam int P_VE_BASE = 3;
    localparam int VE_STRIDE = 3;
    localparam int OFS_INSTR = 0;
    localparam int OFS_GLOBAL = 1;
    localparam int OFS_LOCAL = 2;

    // ==========================================================
    // bank numbering
    localparam int B_CI = 0;
    localparam int B_CD = 1;
    localparam int B_CP = 2;
    localparam int B_VE_BASE = 3;
    localparam int BK_ICACHE = 0;
    localparam int BK_DRAM0 = 1;

    // ==========================================================
    // command widths and reset values
    localparam int CMD_W = 32;
    localparam int CMD_TGT_W = 5;
    localparam logic RST_OFF = 1'b0;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } sel_t;

    typedef struct packed {
        logic write;
        logic [IDX_W-1:0] index;
        logic [DW_BITS-1:0] wdata;
        logic [DW_BYTES-1:0] be;
    } acc_t;

    typedef struct packed {
        logic valid;
        logic [CMD_TGT_W-1:0] targets;
        logic [CMD_W-1:0] word;
    } cmd_t;

endpackage

// ### rtl/bank_arbiter.sv
// per-bank arbiter: fixed priority levels, then token round robin
module bank_arbiter #(
    parameter int SLOTS = 5
) (
    // contenders
    input wire logic i_cpu_req,
    input wire logic [SLOTS-1:0] i_ring_req,
    input wire logic i_te_req,
    input wire logic [$clog2(SLOTS)-1:0] i_token,
    // grants
    output logic o_cpu_gnt,
    output logic [SLOTS-1:0] o_ring_gnt,
    output logic o_te_gnt
);

    // ==========================================================
    // selection
    always_comb begin
        int idx;
        logic found;
        idx = 0;
        found = 1'b0;
        o_cpu_gnt = 1'b0;
        o_ring_gnt = '0;
        o_te_gnt = 1'b0;
        if (i_cpu_req) begin
            o_cpu_gnt = 1'b1; // R15 R16
        end else if (|i_ring_req) begin
            // search starts just after the token holder
            for (int k = 1; k <= SLOTS; k++) begin
                idx = (int'(i_token) + k) % SLOTS;
                if (!found && i_ring_req[idx]) begin
                    found = 1'b1;
                    o_ring_gnt[idx] = 1'b1; // R17
                end
            end
        end else if (i_te_req) begin
            o_te_gnt = 1'b1; // R16
        end
    end

endmodule

// ### rtl/shared_ram_crossbar_arbiter.sv
// crossbar of requester ports onto on-chip ram banks, with commands
//
// Contract
// [R1] bank chosen from request address only
// [R2] two one-cycle stages, accesses overlap
// [R3] each bank grants one access per cycle
// [R4] bank decided each cycle from address msbs
// [R5] cpu instr: own icache; data: listed rams
// [R6] engine instr port reaches own icache only
// [R7] engine global port reaches all engine rams
// [R8] engine local port reaches own rams only
// [R9] transfer engine reaches every ram
// [R10] stage one: msbs in, one grant out
// [R11] stage two: granted port drives doubleword index
// [R12] read data returned by stage two end
// [R13] write bytes land at stage two end
// [R14] losers stall, request held until granted
// [R15] fixed priority first, then round robin
// [R16] order: cpu, vector engine, transfer engine
// [R17] token ring, holder lowest, next highest
// [R18] rr off: token parked at last global
// [R19] rr off: local, global 0 up, last
// [R20] small variant drops engines two and three
// [R21] crossbar carries interprocessor command words
// [R22] only addresses below external base route
// [R23] bad on-chip engine access faults, stalls
// [R24] engine count parameter two or four
module shared_ram_crossbar_arbiter #(
    parameter int NUM_VE = 4,
    parameter int NUM_DRAM = 3,
    localparam int NP = 3 + 3 * NUM_VE,
    localparam int NB = 3 + NUM_VE * (NUM_DRAM + 2),
    localparam int NS = NUM_VE + 1,
    localparam int TW = $clog2(NS),
    localparam int PW = $clog2(NP)
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // configuration
    input wire logic i_rr_enable,
    input wire logic [NUM_VE-1:0] i_ve_soft_rst,
    // memory requests
    input wire xbar_pkg::sel_t i_sel [NP],
    input wire xbar_pkg::acc_t i_acc [NP],
    // memory answers
    output logic [NP-1:0] o_grant,
    output logic [NP-1:0] o_rvalid,
    output logic [xbar_pkg::DW_BITS-1:0] o_rdata [NP],
    output logic [NUM_VE-1:0] o_fault,
    // command words
    input wire xbar_pkg::cmd_t i_cmd [NS],
    output logic [NS-1:0] o_cmd_taken,
    output logic o_cmd_valid,
    output logic [NS-1:0] o_cmd_targets,
    output logic [xbar_pkg::CMD_W-1:0] o_cmd_word,
    output logic [TW-1:0] o_cmd_src
);

    localparam int BSTRIDE = NUM_DRAM + 2; // R20 R24
    localparam logic [TW-1:0] TOKEN_PARK = TW'(NS - 1);

    // ==========================================================
    // decoding functions
    function automatic int bank_of(input logic [31:0] addr);
        int b;
        b = int'(addr[xbar_pkg::BANK_LSB +: xbar_pkg::BANK_W]);
        if (addr >= xbar_pkg::EXT_BASE
            || addr[xbar_pkg::ONCHIP_MSB:xbar_pkg::BANK_LSB
                    + xbar_pkg::BANK_W] != '0) begin
            return -1; // R22
        end
        return (b < NB) ? b : -1; // R1 R4
    endfunction
    function automatic logic reaches(input int p, input int b);
        int e;
        int k;
        int be;
        int bk;
        e = (p - xbar_pkg::P_VE_BASE) / xbar_pkg::VE_STRIDE;
        k = (p - xbar_pkg::P_VE_BASE) % xbar_pkg::VE_STRIDE;
        be = (b - xbar_pkg::B_VE_BASE) / BSTRIDE;
        bk = (b - xbar_pkg::B_VE_BASE) % BSTRIDE;
        if (b < 0 || b >= NB) begin
            return 1'b0;
        end
        if (p == xbar_pkg::P_TE) begin
            return 1'b1; // R9
        end
        if (p == xbar_pkg::P_CI) begin
            return b == xbar_pkg::B_CI; // R5
        end
        if (p == xbar_pkg::P_CD) begin
            return b == xbar_pkg::B_CD || b == xbar_pkg::B_CP
                || (b >= xbar_pkg::B_VE_BASE
                    && bk != xbar_pkg::BK_ICACHE); // R5
        end
        if (b < xbar_pkg::B_VE_BASE) begin
            return 1'b0;
        end
        if (k == xbar_pkg::OFS_INSTR) begin
            return be == e && bk == xbar_pkg::BK_ICACHE; // R6
        end
        if (k == xbar_pkg::OFS_GLOBAL) begin
            return bk != xbar_pkg::BK_ICACHE; // R7
        end
        return be == e && bk != xbar_pkg::BK_ICACHE; // R8
    endfunction
    function automatic int cpu_port(input int b);
        return (b == xbar_pkg::B_CI) ? xbar_pkg::P_CI : xbar_pkg::P_CD;
    endfunction
    // slot 0 is the bank owner's own port, slots 1.. the globals
    function automatic int slot_port(input int s, input int b);
        int e;
        int bk;
        e = (b - xbar_pkg::B_VE_BASE) / BSTRIDE;
        bk = (b - xbar_pkg::B_VE_BASE) % BSTRIDE;
        if (s == 0) begin
            return xbar_pkg::P_VE_BASE + xbar_pkg::VE_STRIDE * e
                + ((bk == xbar_pkg::BK_ICACHE) ? xbar_pkg::OFS_INSTR
                                               : xbar_pkg::OFS_LOCAL);
        end
        return xbar_pkg::P_VE_BASE + xbar_pkg::VE_STRIDE * (s - 1)
            + xbar_pkg::OFS_GLOBAL;
    endfunction
    function automatic int ve_of(input int p);
        return (p - xbar_pkg::P_VE_BASE) / xbar_pkg::VE_STRIDE;
    endfunction

    // ==========================================================
    // stage one: request decode
    logic [NP-1:0] want [NB];
    logic [NUM_VE-1:0] bad;

    always_comb begin
        int bk;
        logic elig;
        bk = -1;
        elig = 1'b0;
        for (int b = 0; b < NB; b++) begin
            want[b] = '0;
        end
        for (int p = 0; p < NP; p++) begin
            bk = bank_of(i_sel[p].addr);
            // a port in its stage two cycle is not arbitrated again
            elig = i_sel[p].valid && !o_grant[p];
            if (p >= xbar_pkg::P_VE_BASE && o_fault[ve_of(p)]) begin
                elig = 1'b0; // R23
            end
            for (int b = 0; b < NB; b++) begin
                if (elig && bk == b && reaches(p, b)) begin
                    want[b][p] = 1'b1; // R1 R10
                end
            end
        end
    end

    always_comb begin
        bad = '0;
        for (int p = xbar_pkg::P_VE_BASE; p < NP; p++) begin
            if (i_sel[p].valid && i_sel[p].addr < xbar_pkg::EXT_BASE
                && !reaches(p, bank_of(i_sel[p].addr))) begin
                bad[ve_of(p)] = 1'b1; // R23
            end
        end
    end

    // ==========================================================
    // per-bank arbitration, token and ram
    logic [NP-1:0] gnt [NB];
    logic own_v_reg [NB];
    logic [PW-1:0] own_reg [NB];
    logic [xbar_pkg::DW_BITS-1:0] rd [NB];

    for (genvar b = 0; b < NB; b++) begin : g_bank
        logic [NS-1:0] ring_req;
        logic [NS-1:0] ring_gnt;
        logic cpu_gnt;
        logic te_gnt;
        logic [TW-1:0] token_reg;
        logic [xbar_pkg::DW_BITS-1:0] mem [xbar_pkg::DEPTH];
        xbar_pkg::acc_t acc;
        always_comb begin
            ring_req = '0;
            if (b >= xbar_pkg::B_VE_BASE) begin
                for (int s = 0; s < NS; s++) begin
                    ring_req[s] = want[b][slot_port(s, b)];
                end
            end
        end
        bank_arbiter #(
            .SLOTS(NS)
        ) u_arb (
            .i_cpu_req(want[b][cpu_port(b)]),
            .i_ring_req(ring_req),
            .i_te_req(want[b][xbar_pkg::P_TE]),
            .i_token(token_reg),
            .o_cpu_gnt(cpu_gnt),
            .o_ring_gnt(ring_gnt),
            .o_te_gnt(te_gnt)
        );
        always_comb begin
            gnt[b] = '0;
            gnt[b][cpu_port(b)] = cpu_gnt; // R3 R15
            gnt[b][xbar_pkg::P_TE] = te_gnt;
            if (b >= xbar_pkg::B_VE_BASE) begin
                for (int s = 0; s < NS; s++) begin
                    if (ring_gnt[s]) begin
                        gnt[b][slot_port(s, b)] = 1'b1;
                    end
                end
            end
        end
        // token moves to the winner; parked when rr is off
        always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
                token_reg <= TOKEN_PARK;
            end else if (!i_rr_enable) begin
                token_reg <= TOKEN_PARK; // R18 R19
            end else begin
                for (int s = 0; s < NS; s++) begin
                    if (ring_gnt[s]) begin
                        token_reg <= TW'(s); // R17
                    end
                end
            end
        end
        // owner of the stage two slot
        always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
                own_v_reg[b] <= 1'b0;
                own_reg[b] <= '0;
            end else begin
                own_v_reg[b] <= |gnt[b]; // R2
                for (int p = 0; p < NP; p++) begin
                    if (gnt[b][p]) begin
                        own_reg[b] <= PW'(p);
                    end
                end
            end
        end

        assign acc = i_acc[own_reg[b]]; // R11
        assign rd[b] = mem[acc.index];

        always_ff @(posedge i_clk) begin
            if (own_v_reg[b] && acc.write) begin
                for (int i = 0; i < xbar_pkg::DW_BYTES; i++) begin
                    if (acc.be[i]) begin
                        mem[acc.index][8*i +: 8] <= acc.wdata[8*i +: 8]; // R13
                    end
                end
            end
        end
    end

    // ==========================================================
    // grants and read return
    logic [NP-1:0] grant_any;

    always_comb begin
        grant_any = '0;
        for (int b = 0; b < NB; b++) begin
            grant_any = grant_any | gnt[b];
        end
    end

    // a port without grant simply sees no grant and holds its request
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_grant <= '0;
        end else begin
            o_grant <= grant_any; // R10 R14
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rvalid <= '0;
            for (int p = 0; p < NP; p++) begin
                o_rdata[p] <= '0;
            end
        end else begin
            o_rvalid <= '0;
            for (int b = 0; b < NB; b++) begin
                if (own_v_reg[b] && !i_acc[own_reg[b]].write) begin
                    o_rvalid[own_reg[b]] <= 1'b1; // R12
                    o_rdata[own_reg[b]] <= rd[b];
                end
            end
        end
    end

    // ==========================================================
    // engine faults
    always_ff @(posedge i_clk) begin
        for (int e = 0; e < NUM_VE; e++) begin
            if (i_sys_rst || i_ve_soft_rst[e]) begin
                o_fault[e] <= xbar_pkg::RST_OFF;
            end else if (bad[e]) begin
                o_fault[e] <= 1'b1; // R23
            end
        end
    end

    // ==========================================================
    // command words: lowest sender index not taken last cycle wins a cycle
    logic [NS-1:0] cmd_pick;
    logic [TW-1:0] cmd_idx;

    always_comb begin
        cmd_pick = '0;
        cmd_idx = '0;
        for (int s = NS - 1; s >= 0; s--) begin
            if (i_cmd[s].valid && !o_cmd_taken[s]) begin
                cmd_pick = '0;
                cmd_pick[s] = 1'b1;
                cmd_idx = TW'(s);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_cmd_taken <= '0;
            o_cmd_valid <= 1'b0;
            o_cmd_targets <= '0;
            o_cmd_word <= '0;
            o_cmd_src <= '0;
        end else begin
            o_cmd_taken <= cmd_pick;
            o_cmd_valid <= |cmd_pick; // R21
            o_cmd_targets <= |cmd_pick ? i_cmd[cmd_idx].targets[NS-1:0] : '0;
            o_cmd_word <= i_cmd[cmd_idx].word;
            o_cmd_src <= cmd_idx;
        end
    end

endmodule

// ### verif/xbar_checker.sv
// port assertions for the ram crossbar
module xbar_checker #(
    parameter int NUM_VE = 4,
    parameter int NUM_DRAM = 3,
    localparam int NP = 3 + 3 * NUM_VE,
    localparam int NB = 3 + NUM_VE * (NUM_DRAM + 2),
    localparam int TW = $clog2(NUM_VE + 1)
) (
    // clock and control
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [NUM_VE-1:0] i_ve_soft_rst,
    // requests
    input wire xbar_pkg::sel_t i_sel [NP],
    input wire xbar_pkg::acc_t i_acc [NP],
    // answers
    input wire logic [NP-1:0] o_grant,
    input wire logic [NP-1:0] o_rvalid,
    input wire logic [xbar_pkg::DW_BITS-1:0] o_rdata [NP],
    input wire logic [NUM_VE-1:0] o_fault,
    input wire logic o_cmd_valid,
    input wire logic [NUM_VE:0] o_cmd_taken,
    input wire logic [TW-1:0] o_cmd_src
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    logic [xbar_pkg::BANK_W-1:0] bank_reg [NP];
    logic [NP-1:0] hit [NB];

    // ========
    // bank asked for one cycle back
    always_ff @(posedge i_clk) begin
        for (int p = 0; p < NP; p++) begin
            bank_reg[p] <= i_sel[p].addr[16:11];
        end
    end
    always_comb begin
        for (int b = 0; b < NB; b++) begin
            for (int p = 0; p < NP; p++) begin
                hit[b][p] = o_grant[p] && bank_reg[p] == b;
            end
        end
    end

    // ========
    // assertions
    for (genvar p = 0; p < NP; p++) begin : g_port
        a_grant_has_req:
        assert property (o_grant[p] |-> $past(i_sel[p].valid))
            else $error("grant without request");
        a_grant_in_map:
        assert property (o_grant[p] |-> $past(i_sel[p].addr[31:17]) == '0)
            else $error("grant outside on-chip map");
        a_read_answer:
        assert property (!$past(i_sys_rst) |-> o_rvalid[p] ==
            ($past(o_grant[p]) && !$past(i_acc[p].write)))
            else $error("read answer misplaced");
        a_rdata_holds:
        assert property (!o_rvalid[p] && !$past(i_sys_rst)
            |-> $stable(o_rdata[p]))
            else $error("read data moved");
    end
    for (genvar b = 0; b < NB; b++) begin : g_bank
        a_one_grant_bank:
        assert property ($onehot0(hit[b])) else $error("bank granted twice");
    end
    for (genvar e = 0; e < NUM_VE; e++) begin : g_eng
        a_fault_sticky:
        assert property (o_fault[e] && !i_ve_soft_rst[e] |=> o_fault[e])
            else $error("fault dropped");
        a_fault_clear:
        assert property (i_ve_soft_rst[e] |=> !o_fault[e])
            else $error("fault kept");
    end
    a_cmd_one_taken:
    assert property (o_cmd_taken == (o_cmd_valid ? 1 << o_cmd_src : 0))
        else $error("command take mismatch");
endmodule

bind shared_ram_crossbar_arbiter xbar_checker #(
    .NUM_VE(NUM_VE), .NUM_DRAM(NUM_DRAM)
) u_xbar_checker (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ve_soft_rst(i_ve_soft_rst),
    .i_sel(i_sel), .i_acc(i_acc), .o_grant(o_grant), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata), .o_fault(o_fault), .o_cmd_valid(o_cmd_valid),
    .o_cmd_taken(o_cmd_taken), .o_cmd_src(o_cmd_src)
);

// ### verif/requester_model.sv
// requester: holds a request until granted, then lets go
module requester_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // bench side
    input wire logic i_start,
    input wire logic [31:0] i_addr,
    input wire xbar_pkg::acc_t i_acc,
    output logic o_busy,
    // crossbar side
    input wire logic i_grant,
    output xbar_pkg::sel_t o_sel,
    output xbar_pkg::acc_t o_acc
);
    logic [31:0] addr_reg;
    xbar_pkg::acc_t acc_reg;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_busy <= 1'b0;
        end else if (i_start) begin
            o_busy <= 1'b1;
            addr_reg <= i_addr;
            acc_reg <= i_acc;
        end else if (o_busy && i_grant) begin
            o_busy <= 1'b0;
            addr_reg <= ~addr_reg;
        end
    end
    assign o_sel = {o_busy, addr_reg};
    // lower fields valid only while granted
    assign o_acc = i_grant ? acc_reg : ~acc_reg;
endmodule

// ### verif/testbench.sv
// random and corner-case bench for the ram crossbar
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NV = 2;
    localparam int NP = 3 + 3 * NV;
    localparam int NB = 3 + NV * 5;
    localparam int NS = NV + 1;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic rr_en = 1'b1;
    logic [NV-1:0] soft_rst = '0;
    logic abort = 1'b0;
    logic [NP-1:0] start = '0;
    logic [NP-1:0] busy, grant, rvalid;
    logic [NV-1:0] fault;
    logic [31:0] req_addr [NP];
    xbar_pkg::acc_t req_acc [NP];
    xbar_pkg::sel_t sel [NP];
    xbar_pkg::acc_t acc [NP];
    xbar_pkg::cmd_t cmd [NS];
    logic [63:0] rdata [NP];
    logic [63:0] rd [NP];
    logic [31:0] gc [NP];
    logic [31:0] cyc = '0;
    logic [NS-1:0] cmd_taken, cmd_tgt;
    logic cmd_valid;
    logic [31:0] cmd_word;
    logic [1:0] cmd_src;
    logic [31:0] seed = 32'h5049CF4D;
    int fail_count = 0;
    int check_count = 0;

    always #50 i_clk = ~i_clk;

    shared_ram_crossbar_arbiter #(.NUM_VE(NV), .NUM_DRAM(3)) DUT (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rr_enable(rr_en),
        .i_ve_soft_rst(soft_rst), .i_sel(sel), .i_acc(acc),
        .o_grant(grant), .o_rvalid(rvalid), .o_rdata(rdata),
        .o_fault(fault), .i_cmd(cmd), .o_cmd_taken(cmd_taken),
        .o_cmd_valid(cmd_valid), .o_cmd_targets(cmd_tgt),
        .o_cmd_word(cmd_word), .o_cmd_src(cmd_src));
    for (genvar p = 0; p < NP; p++) begin : g_req
        requester_model u_req (.i_clk(i_clk), .i_sys_rst(i_sys_rst | abort),
            .i_start(start[p]), .i_addr(req_addr[p]), .i_acc(req_acc[p]),
            .o_busy(busy[p]), .i_grant(grant[p]), .o_sel(sel[p]),
            .o_acc(acc[p]));
    end

    // ========
    // helpers
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [31:0] adr(int b, int i);
        return 32'((b << xbar_pkg::BANK_LSB) + (i << xbar_pkg::DW_LSB));
    endfunction
    function automatic bit reach(int p, int b);
        int eb;
        eb = 3 + 5 * ((p - 3) / 3);
        if (b >= NB) return 0;
        if (p == 0) return b == 0;
        if (p == 1) return b == 1 || b == 2 || (b > 2 && (b - 3) % 5 != 0);
        if (p == 2) return 1;
        if ((p - 3) % 3 == 0) return b == eb;
        if ((p - 3) % 3 == 1) return b > 2 && (b - 3) % 5 != 0;
        return b > eb && b <= eb + 4;
    endfunction
    function automatic logic [63:0] merge(logic [63:0] m, logic [63:0] d,
                                          logic [7:0] be);
        for (int i = 0; i < 8; i++) if (be[i]) m[8*i +: 8] = d[8*i +: 8];
        return m;
    endfunction
    task automatic check(string name, logic [63:0] exp, logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic put(int p, logic [31:0] a, logic w, logic [63:0] d,
                       logic [7:0] be);
        start[p] <= 1'b1;
        req_addr[p] <= a;
        req_acc[p] <= {w, a[10:3], d, be};
    endtask
    task automatic launch();
        int n;
        @(posedge i_clk);
        start <= '0;
        @(negedge i_clk);
        for (n = 0; busy !== '0 && n < 50; n++) @(negedge i_clk);
        check("busy", '0, 64'(busy));
        repeat (2) @(posedge i_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        for (int p = 0; p < NP; p++) begin
            if (grant[p]) gc[p] <= cyc;
            if (rvalid[p]) rd[p] <= rdata[p];
        end
        if (cyc == 5000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        int p, q, b, idx, n;
        logic [63:0] wd, mem;
        logic [7:0] be;
        for (int i = 0; i < NP; i++) req_addr[i] = '0;
        for (int i = 0; i < NP; i++) req_acc[i] = '0;
        for (int i = 0; i < NS; i++) cmd[i] = '0;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int it = 0; it < 12; it++) begin
            p = int'(rnd() % NP);
            do b = int'(rnd() % NB); while (!reach(p, b));
            idx = it == 0 ? 255 : int'(rnd() % 256);
            wd = {rnd(), rnd()};
            put(p, adr(b, idx), 1'b1, wd, 8'hFF);
            launch();
            mem = wd;
            be = 8'(rnd());
            wd = {rnd(), rnd()};
            put(p, adr(b, idx), 1'b1, wd, be);
            launch();
            mem = merge(mem, wd, be);
            do q = int'(rnd() % NP); while (!reach(q, b));
            put(q, adr(b, idx), 1'b0, ~wd, ~be);
            launch();
            check("read data", mem, rd[q]);
        end
        put(1, adr(7, 0), 1'b0, '0, '0);
        put(4, adr(7, 0), 1'b0, '0, '0);
        put(2, adr(7, 0), 1'b0, '0, '0);
        launch();
        check("engine after cpu", 64'(gc[1] + 1), 64'(gc[4]));
        check("transfer last", 64'(gc[1] + 2), 64'(gc[2]));
        for (int r = 0; r < 2; r++) begin
            p = r ? 4 : 7;
            q = r ? 7 : 4;
            put(p, adr(4, 1), 1'b0, '0, '0);
            launch();
            put(4, adr(4, 1), 1'b0, '0, '0);
            put(7, adr(4, 1), 1'b0, '0, '0);
            launch();
            check("token order", 64'(gc[q] + 1), 64'(gc[p]));
        end
        rr_en <= 1'b0;
        put(5, adr(4, 2), 1'b0, '0, '0);
        put(4, adr(4, 2), 1'b0, '0, '0);
        put(7, adr(4, 2), 1'b0, '0, '0);
        launch();
        check("local first", 64'(gc[5] + 1), 64'(gc[4]));
        check("last global", 64'(gc[5] + 2), 64'(gc[7]));
        put(5, adr(1, 0), 1'b0, '0, '0);
        put(1, xbar_pkg::EXT_BASE, 1'b0, '0, '0);
        put(2, adr(NB, 0), 1'b0, '0, '0);
        @(posedge i_clk);
        start <= '0;
        repeat (10) @(negedge i_clk);
        check("fault", 64'h1, 64'(fault));
        check("stalled", 64'h26, 64'(busy));
        @(posedge i_clk);
        soft_rst <= 2'h1;
        abort <= 1'b1;
        @(posedge i_clk);
        soft_rst <= '0;
        abort <= 1'b0;
        cmd[0] <= {1'b1, 5'h02, 32'h1111_0000};
        cmd[2] <= {1'b1, 5'h01, 32'h2222_0000};
        repeat (2) @(negedge i_clk);
        check("fault cleared", '0, 64'(fault));
        for (int k = 0; k < 3; k += 2) begin
            for (n = 0; cmd_valid !== 1'b1 && n < 20; n++) @(negedge i_clk);
            check("cmd source", 64'(k), 64'(cmd_src));
            check("cmd word", 64'(cmd[k].word), 64'(cmd_word));
            check("dest", 64'(cmd[k].targets[NS-1:0]), 64'(cmd_tgt));
            check("cmd taken", 64'(1 << k), 64'(cmd_taken));
            @(posedge i_clk);
            cmd[k].valid <= 1'b0;
            @(negedge i_clk);
        end
        repeat (4) @(posedge i_clk);
        finish_test();
    end
endmodule
